// ### hw/monitor_serial_command_port.sv
// monitor command port: echoes bytes, decodes commands, drives a memory bus
// assumes memRdata is valid in the same cycle memRe is high
`timescale 1ns/1ps
// Function
// RULE_01 - bytes use mark/space signalling at one common bit rate
// RULE_02 - start bit plus nine more low bits is a break
// RULE_03 - on break, drive wire high two bits, then send a break back
// RULE_04 - external oscillator: bit period is 256 bus clocks
// RULE_05 - internal oscillator forced monitor: bit period is 335 bus clocks
// RULE_06 - six commands: read, write, indexed read/write, stack pointer read, run
// RULE_07 - every received byte is echoed on the same pin; the code echoes only bytes received in S_OPC and S_OPND
// RULE_08 - wait eleven bits after last byte; a break then cancels the command
// RULE_09 - two-bit gap before each echo and before returned read data
// RULE_10 - read data is sent only after the last byte's echo
// RULE_11 - host waits at least one bit after each echo
// RULE_12 - read opcode 4a with address high then low, returns the byte
// RULE_13 - indexed reads and writes step through consecutive addresses
// RULE_14 - frame: low start, eight data bits lsb first, high stop
// RULE_15 - opcodes other than read are configurable constants
module monitor_serial_command_port
    import mon_pkg::*;
#(
    parameter logic [7:0] OPC_READ = 8'h4a,
    parameter logic [7:0] OPC_WRITE = 8'h4b,
    parameter logic [7:0] OPC_IDX_READ = 8'h4c,
    parameter logic [7:0] OPC_IDX_WRITE = 8'h4d,
    parameter logic [7:0] OPC_SP_READ = 8'h4e,
    parameter logic [7:0] OPC_RUN = 8'h4f
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // oscillator mode, high for internal oscillator forced monitor
    input wire logic forcedIntOsc,
    // monitor data pin
    input wire logic dataIn,
    output logic dataOut,
    output logic dataOe,
    // memory bus
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    output logic memWe,
    output logic memRe,
    input wire logic [7:0] memRdata,
    // cpu state
    input wire logic [15:0] stackPtr,
    output logic runStart
);
    typedef enum logic [2:0] {
        S_OPC, S_OPND, S_ECHO, S_DELAY, S_EXEC, S_FETCH, S_SEND
    } state_e;

    mon_link_if lnk ();

    state_e st_r;
    cmd_e cmd_r;
    logic [1:0] need_r;
    logic [23:0] opnd_r;
    logic [15:0] ptr_r, memAddr_r;
    logic [12:0] dly_r, dlyLim;
    logic [7:0] spLo_r, txByte_r, memWdata_r;
    logic left_r, txStart_r, memWe_r, memRe_r, runStart_r;
    cmd_e rxCmd;

    mon_serial_phy u_phy (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .forcedIntOsc(forcedIntOsc),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .lnk(lnk)
    );

    // opcode decode
    function automatic cmd_e decode(input logic [7:0] b);
        cmd_e c;
        c = CMD_NONE;
        if (b == OPC_READ) c = CMD_READ; // see RULE_12
        else if (b == OPC_WRITE) c = CMD_WRITE; // see RULE_15
        else if (b == OPC_IDX_READ) c = CMD_IDX_READ;
        else if (b == OPC_IDX_WRITE) c = CMD_IDX_WRITE;
        else if (b == OPC_SP_READ) c = CMD_SP_READ;
        else if (b == OPC_RUN) c = CMD_RUN;
        return c;
    endfunction : decode

    // operand bytes per command
    function automatic logic [1:0] needOf(input cmd_e c);
        logic [1:0] n;
        n = 2'h0;
        if (c == CMD_READ) n = OPND_READ;
        else if (c == CMD_WRITE) n = OPND_WRITE;
        else if (c == CMD_IDX_WRITE) n = OPND_IDX_WRITE;
        return n;
    endfunction : needOf

    // link and bus outputs
    assign rxCmd = decode(lnk.rxByte);
    assign dlyLim = DLY_W'(DELAY_BITS * lnk.bitLen);
    assign lnk.txByte = txByte_r;
    assign lnk.txStart = txStart_r;
    assign memAddr = memAddr_r;
    assign memWdata = memWdata_r;
    assign memWe = memWe_r;
    assign memRe = memRe_r;
    assign runStart = runStart_r;

    // command sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= S_OPC;
            cmd_r <= CMD_NONE;
            need_r <= 2'h0;
            opnd_r <= 24'h000000;
            ptr_r <= 16'h0000;
            dly_r <= 13'h0000;
            spLo_r <= 8'h00;
            left_r <= 1'h0;
            txByte_r <= 8'h00;
            txStart_r <= 1'h0;
            memAddr_r <= 16'h0000;
            memWdata_r <= 8'h00;
            memWe_r <= 1'h0;
            memRe_r <= 1'h0;
            runStart_r <= 1'h0;
        end else begin
            txStart_r <= 1'h0;
            memWe_r <= 1'h0;
            memRe_r <= 1'h0;
            runStart_r <= 1'h0;
            unique case (st_r)
                S_OPC: begin
                    if (lnk.rxValid) begin
                        cmd_r <= rxCmd; // see RULE_06
                        need_r <= needOf(rxCmd);
                        txByte_r <= lnk.rxByte; // see RULE_07
                        txStart_r <= 1'h1;
                        st_r <= S_ECHO;
                    end
                end
                S_OPND: begin
                    if (lnk.rxValid) begin
                        opnd_r <= {opnd_r[15:0], lnk.rxByte}; // high byte first
                        need_r <= need_r - 2'h1;
                        txByte_r <= lnk.rxByte; // see RULE_07
                        txStart_r <= 1'h1;
                        st_r <= S_ECHO;
                    end
                end
                S_ECHO: begin
                    dly_r <= 13'h0000;
                    if (lnk.txDone) begin
                        if (cmd_r == CMD_NONE) st_r <= S_OPC;
                        else if (need_r != 2'h0) st_r <= S_OPND;
                        else st_r <= S_DELAY;
                    end
                end
                S_DELAY: begin
                    if (dly_r == dlyLim - 13'h0001) st_r <= S_EXEC; // see RULE_08
                    else dly_r <= dly_r + 13'h0001;
                end
                S_EXEC: begin
                    st_r <= S_OPC;
                    unique case (cmd_r)
                        CMD_READ: begin
                            memAddr_r <= opnd_r[15:0]; // see RULE_12
                            memRe_r <= 1'h1;
                            ptr_r <= opnd_r[15:0] + 16'h0001;
                            left_r <= 1'h0;
                            st_r <= S_FETCH;
                        end
                        CMD_WRITE: begin
                            memAddr_r <= opnd_r[23:8];
                            memWdata_r <= opnd_r[7:0];
                            memWe_r <= 1'h1;
                            ptr_r <= opnd_r[23:8] + 16'h0001;
                        end
                        CMD_IDX_READ: begin
                            memAddr_r <= ptr_r;
                            memRe_r <= 1'h1;
                            ptr_r <= ptr_r + 16'h0001; // see RULE_13
                            left_r <= 1'h1;
                            st_r <= S_FETCH;
                        end
                        CMD_IDX_WRITE: begin
                            memAddr_r <= ptr_r;
                            memWdata_r <= opnd_r[7:0];
                            memWe_r <= 1'h1;
                            ptr_r <= ptr_r + 16'h0001; // see RULE_13
                        end
                        CMD_SP_READ: begin
                            txByte_r <= stackPtr[15:8];
                            spLo_r <= stackPtr[7:0];
                            txStart_r <= 1'h1; // see RULE_10
                            left_r <= 1'h1;
                            st_r <= S_SEND;
                        end
                        CMD_RUN: runStart_r <= 1'h1;
                        CMD_NONE: st_r <= S_OPC;
                    endcase
                end
                S_FETCH: begin
                    txByte_r <= memRdata;
                    txStart_r <= 1'h1; // phy adds the gap, see RULE_09
                    st_r <= S_SEND;
                end
                S_SEND: begin
                    if (lnk.txDone) begin
                        if (!left_r) begin
                            st_r <= S_OPC;
                        end else if (cmd_r == CMD_SP_READ) begin
                            left_r <= 1'h0;
                            txByte_r <= spLo_r;
                            txStart_r <= 1'h1;
                        end else begin
                            left_r <= 1'h0;
                            memAddr_r <= ptr_r;
                            memRe_r <= 1'h1;
                            ptr_r <= ptr_r + 16'h0001; // see RULE_13
                            st_r <= S_FETCH;
                        end
                    end
                end
            endcase
            if (lnk.rxBreak) st_r <= S_OPC; // break cancels, see RULE_08
        end
    end

    a_echo_byte: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_07
        (st_r == S_OPC || st_r == S_OPND) && lnk.rxValid
            |=> txStart_r && txByte_r == $past(lnk.rxByte))
        else $error("received byte not echoed");
    a_break_cancel: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_08
        st_r == S_DELAY && lnk.rxBreak |=> st_r == S_OPC && !memWe_r && !memRe_r)
        else $error("break did not cancel command");
    a_delay_length: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_08
        $rose(st_r == S_EXEC) |-> $past(dly_r) == dlyLim - 13'h0001)
        else $error("execute before eleven bit delay");
    a_read_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_12
        memRe_r && cmd_r == CMD_READ |-> memAddr_r == opnd_r[15:0] ##1 txStart_r)
        else $error("read address or return wrong");
    a_index_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_13
        (memWe_r || memRe_r) && (cmd_r == CMD_IDX_WRITE || cmd_r == CMD_IDX_READ)
            |-> ptr_r == memAddr_r + 16'h0001)
        else $error("index pointer did not step");
    a_send_idle_link: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_10
        txStart_r |-> !lnk.txBusy)
        else $error("data started during an echo");
endmodule : monitor_serial_command_port

// ### hw/mon_pkg.sv
// monitor port package: bit timing, frame layout, command set
// assumes one 200 MHz bus clock drives the whole monitor port
package mon_pkg;
    // bit period in bus clock cycles per oscillator source
    localparam int BIT_CYC_EXT = 256;
    localparam int BIT_CYC_INT = 335;
    localparam int CNT_W = 9;
    // frame layout: start, eight data, stop
    localparam int FRAME_BITS = 10;
    // driven-high gap ahead of every transmitted frame
    localparam int GAP_BITS = 2;
    // gap plus frame, one transmit slot
    localparam int SLOT_BITS = GAP_BITS + FRAME_BITS;
    // quiet time after a command's last byte
    localparam int DELAY_BITS = 11;
    localparam int DLY_W = 13;
    // operand byte counts
    localparam logic [1:0] OPND_READ = 2'h2;
    localparam logic [1:0] OPND_WRITE = 2'h3;
    localparam logic [1:0] OPND_IDX_WRITE = 2'h1;
    // line level and tx shift word after reset
    localparam logic LINE_IDLE = 1'h1;
    localparam logic [11:0] TX_SH_RST = 12'hfff;
    // monitor commands
    typedef enum logic [2:0] {
        CMD_NONE, CMD_READ, CMD_WRITE, CMD_IDX_READ, CMD_IDX_WRITE, CMD_SP_READ, CMD_RUN
    } cmd_e;
endpackage : mon_pkg

// ### hw/mon_link_if.sv
// byte link between the monitor command sequencer and its serial engine
// assumes both ends share ref_clk; strobes are one-cycle pulses
`timescale 1ns/1ps
interface mon_link_if;
    logic [7:0] rxByte;
    logic rxValid;
    logic rxBreak;
    logic [7:0] txByte;
    logic txStart;
    logic txDone;
    logic txBusy;
    logic [8:0] bitLen;
    modport phy (output rxByte, rxValid, rxBreak, txDone, txBusy, bitLen,
                 input txByte, txStart);
    modport ctrl (input rxByte, rxValid, rxBreak, txDone, txBusy, bitLen,
                  output txByte, txStart);
endinterface : mon_link_if

// ### hw/mon_serial_phy.sv
// serial engine for the one-wire monitor link: receive, echo slots, break
// assumes dataIn is asynchronous; an external pullup holds the idle wire high
`timescale 1ns/1ps
module mon_serial_phy
    import mon_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // oscillator mode
    input wire logic forcedIntOsc,
    // monitor data pin
    input wire logic dataIn,
    output logic dataOut,
    output logic dataOe,
    // byte link
    mon_link_if.phy lnk
);
    typedef enum logic [1:0] {R_IDLE, R_BITS, R_HOLD} rx_e;

    logic rxMeta_r, rxLine_r;
    rx_e rxSt_r;
    logic [8:0] rxCnt_r;
    logic [3:0] rxIdx_r;
    logic [7:0] rxSh_r, rxByte_r;
    logic rxValid_r, rxBreak_r;
    logic txBusy_r, txDone_r;
    logic [8:0] txCnt_r;
    logic [3:0] txIdx_r;
    logic [11:0] txSh_r;

    // bit period select
    assign lnk.bitLen = forcedIntOsc ? CNT_W'(BIT_CYC_INT) : CNT_W'(BIT_CYC_EXT); // see RULE_04 RULE_05
    assign lnk.rxByte = rxByte_r;
    assign lnk.rxValid = rxValid_r;
    assign lnk.rxBreak = rxBreak_r;
    assign lnk.txBusy = txBusy_r;
    assign lnk.txDone = txDone_r;
    assign dataOut = txSh_r[0];
    assign dataOe = txBusy_r;

    // two-stage pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxMeta_r <= LINE_IDLE;
            rxLine_r <= LINE_IDLE;
        end else begin
            rxMeta_r <= dataIn;
            rxLine_r <= rxMeta_r;
        end
    end

    // receiver, muted while we drive the wire (half duplex)
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxSt_r <= R_IDLE;
            rxCnt_r <= 9'h000;
            rxIdx_r <= 4'h0;
            rxSh_r <= 8'h00;
            rxByte_r <= 8'h00;
            rxValid_r <= 1'h0;
            rxBreak_r <= 1'h0;
        end else begin
            rxValid_r <= 1'h0;
            rxBreak_r <= 1'h0;
            unique case (rxSt_r)
                R_IDLE: begin
                    if (!txBusy_r && !rxLine_r) begin // see RULE_11
                        rxCnt_r <= lnk.bitLen >> 1; // sample mid-bit
                        rxIdx_r <= 4'h0;
                        rxSt_r <= R_BITS;
                    end
                end
                R_BITS: begin
                    if (rxCnt_r != 9'h000) begin
                        rxCnt_r <= rxCnt_r - 9'h001;
                    end else begin
                        rxCnt_r <= lnk.bitLen - 9'h001;
                        rxIdx_r <= rxIdx_r + 4'h1;
                        if (rxIdx_r == 4'h0) begin
                            if (rxLine_r) rxSt_r <= R_IDLE; // glitch, not a start bit
                        end else if (rxIdx_r == 4'(FRAME_BITS - 1)) begin
                            if (rxLine_r) begin // see RULE_14
                                rxValid_r <= 1'h1;
                                rxByte_r <= rxSh_r;
                                rxSt_r <= R_IDLE;
                            end else begin
                                rxBreak_r <= (rxSh_r == 8'h00); // see RULE_02
                                rxSt_r <= R_HOLD;
                            end
                        end else begin
                            rxSh_r <= {rxLine_r, rxSh_r[7:1]}; // lsb first, see RULE_01
                        end
                    end
                end
                R_HOLD: begin
                    if (rxLine_r) rxSt_r <= R_IDLE; // wait out the low wire
                end
            endcase
        end
    end

    // transmitter: two driven-high bits, then the frame or ten low bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txBusy_r <= 1'h0;
            txDone_r <= 1'h0;
            txCnt_r <= 9'h000;
            txIdx_r <= 4'h0;
            txSh_r <= TX_SH_RST;
        end else begin
            txDone_r <= 1'h0;
            if (!txBusy_r) begin
                txCnt_r <= lnk.bitLen - 9'h001;
                txIdx_r <= 4'h0;
                if (rxBreak_r) begin
                    txBusy_r <= 1'h1;
                    txSh_r <= {10'h000, 2'h3}; // see RULE_03
                end else if (lnk.txStart) begin
                    txBusy_r <= 1'h1;
                    txSh_r <= {1'h1, lnk.txByte, 1'h0, 2'h3}; // see RULE_09 RULE_14
                end
            end else if (txCnt_r != 9'h000) begin
                txCnt_r <= txCnt_r - 9'h001;
            end else begin
                txCnt_r <= lnk.bitLen - 9'h001;
                txSh_r <= {1'h1, txSh_r[11:1]};
                txIdx_r <= txIdx_r + 4'h1;
                if (txIdx_r == 4'(SLOT_BITS - 1)) begin
                    txBusy_r <= 1'h0;
                    txDone_r <= 1'h1;
                end
            end
        end
    end

    a_gap_high: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_09
        txBusy_r && txIdx_r < 4'(GAP_BITS) |-> dataOe && dataOut)
        else $error("gap bit not driven high");
    a_break_reply: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_03
        rxBreak_r |=> txBusy_r && txSh_r[11:2] == 10'h000 && txIdx_r == 4'h0)
        else $error("break not answered");
    a_bit_period: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_04
        txBusy_r && txCnt_r == 9'h000 |=> !txBusy_r || txCnt_r == lnk.bitLen - 9'h001)
        else $error("bit period reload wrong");
    a_rx_muted: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE_01
        txBusy_r && rxSt_r == R_IDLE |=> rxSt_r == R_IDLE)
        else $error("receiver started during own transmit");
endmodule : mon_serial_phy

// ### bench/mon_host_model.sv
// host model on the monitor wire: sends frames and breaks, collects slots
// assumes a pullup on the wire and a bench that sets the bit period
`timescale 1ns/1ps
module mon_host_model (
    // clock
    input wire logic ref_clk,
    // bit period in clocks
    input wire logic [8:0] bitCyc,
    // monitor data pin
    input wire logic dataOut,
    input wire logic dataOe,
    output logic dataIn
);
    logic hostLow = 1'b0;
    int slotCnt = 0;
    logic [11:0] pat;
    int lens[$];
    logic [11:0] pats[$];

    // device drives when enabled, else host pulls low, else pullup
    assign dataIn = dataOe ? dataOut : !hostLow;

    // collect every driven slot, sampled at mid-bit
    always @(posedge ref_clk) begin
        if (dataOe === 1'b1) begin
            if (slotCnt % bitCyc == bitCyc / 2 && slotCnt / bitCyc < 12) begin
                pat[slotCnt / bitCyc] = dataOut;
            end
            slotCnt++;
        end else if (slotCnt != 0) begin
            lens.push_back(slotCnt);
            pats.push_back(pat);
            slotCnt = 0;
        end
    end

    // drive n bits lsb first at the shared rate, then release the wire
    task automatic drive_bits(input logic [9:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            hostLow <= !bits[i];
            repeat (bitCyc - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        hostLow <= 1'b0;
    endtask : drive_bits
endmodule : mon_host_model

// ### bench/test_monitor_serial_command_port.sv
// testbench of the monitor command port: break, read, indexed, stack, run
// assumes the host model on the wire and a combinational memory model
`timescale 1ns/1ps
module test_monitor_serial_command_port;
    import mon_pkg::*;
    localparam logic [7:0] OP_WR = 8'h4b;
    localparam logic [7:0] OP_IR = 8'h4c;
    localparam logic [7:0] OP_IW = 8'h4d;
    localparam logic [7:0] OP_SP = 8'h4e;
    localparam logic [7:0] OP_RN = 8'h4f;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic forcedIntOsc = 1'b1;
    logic [8:0] bitCyc = 9'h14f;
    logic [15:0] stackPtr = 16'h0000;
    logic dataIn, dataOut, dataOe, memWe, memRe, runStart;
    logic [15:0] memAddr, wrAddr, rdAddr, addr;
    logic [7:0] memWdata, memRdata, wrData, d;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int wrCnt = 0;
    int runCnt = 0;
    int w;

    // clock generation
    always #2.5 ref_clk = ~ref_clk;

    // memory contents follow the address
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : mem_byte

    // expected slot: two gap bits, start, data lsb first, stop
    function automatic logic [11:0] slot_of(input logic [7:0] b);
        return {1'b1, b, 1'b0, 2'b11};
    endfunction : slot_of

    assign memRdata = mem_byte(memAddr);

    monitor_serial_command_port #(.OPC_READ(8'h4a), .OPC_WRITE(OP_WR), .OPC_IDX_READ(OP_IR),
        .OPC_IDX_WRITE(OP_IW), .OPC_SP_READ(OP_SP), .OPC_RUN(OP_RN)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .forcedIntOsc(forcedIntOsc), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .memAddr(memAddr), .memWdata(memWdata),
        .memWe(memWe), .memRe(memRe), .memRdata(memRdata), .stackPtr(stackPtr),
        .runStart(runStart));

    mon_host_model host (.ref_clk(ref_clk), .bitCyc(bitCyc), .dataOut(dataOut),
        .dataOe(dataOe), .dataIn(dataIn));

    // watch the memory and run strobes, cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (memWe === 1'b1) begin
            wrCnt++;
            wrAddr = memAddr;
            wrData = memWdata;
        end
        if (memRe === 1'b1) begin
            rdAddr = memAddr;
        end
        if (runStart === 1'b1) begin
            runCnt++;
        end
        if (cycles == 100000) begin // a clean run takes about 95k cycles
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check

    // wait for the next device slot and compare length and bits
    task automatic expect_slot(input logic [11:0] p, output int waited);
        waited = 0;
        while (host.lens.size() == 0 && waited < 40 * bitCyc) begin
            @(posedge ref_clk);
            waited++;
        end
        check(host.lens.size() > 0, "no slot from device");
        if (host.lens.size() > 0) begin
            check(host.lens.pop_front() == 12 * bitCyc, "slot length");
            check(host.pats.pop_front() === p, "slot bits");
        end
    endtask : expect_slot

    // one host byte, its echo, then the host hold-off
    task automatic send_byte(input logic [7:0] b);
        int t;
        host.drive_bits({1'b1, b, 1'b0}, 9);
        expect_slot(slot_of(b), t);
        repeat (bitCyc) @(posedge ref_clk);
    endtask : send_byte

    task automatic wait_count(ref int cnt, input int lim);
        for (int i = 0; i < lim && cnt == 0; i++) begin
            @(posedge ref_clk);
        end
    endtask : wait_count

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        w = $urandom(32'h62a4);
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // break answered at the internal oscillator rate
        host.drive_bits(10'h000, 10);
        expect_slot(12'h003, w);
        repeat (bitCyc) @(posedge ref_clk);
        forcedIntOsc <= 1'b0;
        bitCyc <= 9'h100;
        addr = 16'($urandom);
        stackPtr <= 16'($urandom);
        repeat (4) @(posedge ref_clk);
        // memory read with a random address
        send_byte(8'h4a);
        send_byte(addr[15:8]);
        send_byte(addr[7:0]);
        expect_slot(slot_of(mem_byte(addr)), w);
        check(w >= 22 * 256 - 8 && w <= 22 * 256 + 16, "quiet time");
        check(rdAddr === addr, "read address");
        repeat (bitCyc) @(posedge ref_clk);
        // indexed write lands at the next address
        d = 8'($urandom);
        send_byte(OP_IW);
        send_byte(d);
        wait_count(wrCnt, 13 * 256);
        check(wrCnt == 1 && wrAddr === addr + 16'h1, "write address");
        check(wrData === d, "write data");
        // indexed read continues from there
        send_byte(OP_IR);
        expect_slot(slot_of(mem_byte(addr + 16'h2)), w);
        expect_slot(slot_of(mem_byte(addr + 16'h3)), w);
        repeat (bitCyc) @(posedge ref_clk);
        // stack pointer read, high byte first
        send_byte(OP_SP);
        expect_slot(slot_of(stackPtr[15:8]), w);
        expect_slot(slot_of(stackPtr[7:0]), w);
        repeat (bitCyc) @(posedge ref_clk);
        // run cancelled by a break in the quiet time
        send_byte(OP_RN);
        host.drive_bits(10'h000, 10);
        expect_slot(12'h003, w);
        repeat (2 * 256) @(posedge ref_clk); // already past the eleven-bit execute point
        check(runCnt == 0, "cancelled run started");
        // run executed when left alone
        send_byte(OP_RN);
        wait_count(runCnt, 13 * 256);
        check(runCnt == 1, "run not started");
        complete_run();
    end
endmodule : test_monitor_serial_command_port
